// file: inc/card_status_pkg.sv
// Package: bit layout, state codes and carrier types of the card status word
package card_status_pkg;

  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int STATUS_WIDTH = 32;
  localparam int POS_ARGUMENT_LIMIT = 31;
  localparam int POS_ADDRESS_ALIGN = 30;
  localparam int POS_BLOCK_LENGTH = 29;
  localparam int POS_ERASE_ORDER = 28;
  localparam int POS_ERASE_SELECTION = 27;
  localparam int POS_PROTECTED_WRITE = 26;
  localparam int POS_LOCK_ACTIVE = 25;
  localparam int POS_LOCK_FAULT = 24;
  localparam int POS_COMMAND_CHECK = 23;
  localparam int POS_ILLEGAL_COMMAND = 22;
  localparam int POS_CORRECTION_FAIL = 21;
  localparam int POS_CONTROLLER = 20;
  localparam int POS_GENERAL = 19;
  localparam int POS_STREAM_UNDER = 18;
  localparam int POS_STREAM_OVER = 17;
  localparam int POS_IDENTITY_REWRITE = 16;
  localparam int POS_ERASE_SKIP = 15;
  localparam int POS_CORRECTION_OFF = 14;
  localparam int POS_ERASE_ABANDON = 13;
  localparam int POS_STATE_LSB = 9;
  localparam int STATE_WIDTH = 4;
  localparam int POS_BUFFER_EMPTY = 8;
  localparam int POS_APPLICATION_CMD = 5;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Current state codes, 9 to 15 reserved
  // ------------------------------------------------------------------
  localparam logic [3:0] STATE_IDLE = 4'h0;
  localparam logic [3:0] STATE_READY = 4'h1;
  localparam logic [3:0] STATE_IDENT = 4'h2;
  localparam logic [3:0] STATE_STBY = 4'h3;
  localparam logic [3:0] STATE_TRAN = 4'h4;
  localparam logic [3:0] STATE_DATA = 4'h5;
  localparam logic [3:0] STATE_RCV = 4'h6;
  localparam logic [3:0] STATE_PRG = 4'h7;
  localparam logic [3:0] STATE_DIS = 4'h8;

  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  // One-cycle set pulses from the card controller, all read-to-clear
  typedef struct packed {
    logic argument_limit_fault;
    logic address_align_fault;
    logic block_length_fault;
    logic erase_order_fault;
    logic erase_selection_fault;
    logic protected_write_attempt;
    logic lock_fault;
    logic correction_fail;
    logic controller_fault;
    logic general_fault;
    logic stream_read_underrun;
    logic stream_write_overrun;
    logic identity_register_rewrite_fault;
    logic erase_skip;
    logic erase_abandon;
    logic application_command_expected;
  } fault_events_s;

  // Levels that follow the card state
  typedef struct packed {
    logic lock_active_flag;
    logic correction_bypassed;
    logic buffer_empty;
    logic [3:0] current_state;
  } card_levels_s;

  // One command decoded at the link
  typedef struct packed {
    logic done;
    logic check_fail;
    logic illegal;
  } command_event_s;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_WAIT,
    LINK_TAKE
  } link_state_e;

endpackage

// file: verilog/card_status_register.sv
// Card status word: controller-side flags, link-side command flags, response snapshot
//
// Contract
// - Bit 31 argument argument_limit_fault, read-clear
// - Bit 30 misaligned address, read-clear
// - Bit 29 bad block length, read-clear
// - Bit 28 erase order error, read-clear
// - Bit 27 invalid erase selection, read-clear
// - Bit 26 protected block write attempt, read-clear
// - Bit 25 follows lock state
// - Bit 24 lock fault or locked access
// - Bit 23 command check fail, command-cleared
// - Bit 22 illegal command, command-cleared
// - Bit 21 uncorrectable data, read-clear
// - Bits 20 and 19 faults, read-clear
// - Bit 18 stream read underrun, read-clear
// - Bit 17 stream write overrun, read-clear
// - Bit 16 identity or specific-data rewrite fault
// - Bit 15 erase skipped protected blocks
// - Bit 14 follows correction bypass state
// - Bit 13 erase sequence abandoned, read-clear
// - Bits 12:9 carry current state code
// - Bit 5 application command expected, read-clear
// - Whole word goes into each short response
// - Illegal-command flag clears one valid command later, check-fail flag two valid commands later
`timescale 1ns/100ps

module card_status_register
(
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire card_status_pkg::fault_events_s FAULT_EVENTS_I,
  input wire card_status_pkg::card_levels_s CARD_LEVELS_I,
  input wire logic CARD_CLK_I,
  input wire card_status_pkg::command_event_s COMMAND_EVENT_I,
  input wire logic RESPONSE_LOAD_I,
  output logic [31:0] STATUS_WORD_O,
  output logic STATUS_VALID_O,
  output logic SNAPSHOT_BUSY_O
);
  import card_status_pkg::*;

  // ------------------------------------------------------------------
  // Layout masks
  // ------------------------------------------------------------------
  function automatic logic [31:0] bit_mask(input int pos);
    return 32'h0000_0001 << pos;
  endfunction

  function automatic logic [31:0] field_mask(input int lsb, input int width);
    logic [31:0] mask;
    mask = 32'h0000_0000;
    for (int i = 0; i < width; i++)
      mask = mask | bit_mask(lsb + i);
    return mask;
  endfunction

  // Counts set bits, so two fields that share one position are caught
  function automatic int count_bits(input logic [31:0] mask);
    int total;
    total = 0;
    for (int i = 0; i < STATUS_WIDTH; i++)
      total = total + int'(mask[i]);
    return total;
  endfunction

  // Flags set by controller events and cleared when a snapshot is taken
  localparam logic [31:0] READ_CLEAR_MASK =
    bit_mask(POS_ARGUMENT_LIMIT) |
    bit_mask(POS_ADDRESS_ALIGN) |
    bit_mask(POS_BLOCK_LENGTH) |
    bit_mask(POS_ERASE_ORDER) |
    bit_mask(POS_ERASE_SELECTION) |
    bit_mask(POS_PROTECTED_WRITE) |
    bit_mask(POS_LOCK_FAULT) |
    bit_mask(POS_CORRECTION_FAIL) |
    bit_mask(POS_CONTROLLER) |
    bit_mask(POS_GENERAL) |
    bit_mask(POS_STREAM_UNDER) |
    bit_mask(POS_STREAM_OVER) |
    bit_mask(POS_IDENTITY_REWRITE) |
    bit_mask(POS_ERASE_SKIP) |
    bit_mask(POS_ERASE_ABANDON) |
    bit_mask(POS_APPLICATION_CMD);

  localparam logic [31:0] LEVEL_MASK =
    bit_mask(POS_LOCK_ACTIVE) |
    bit_mask(POS_CORRECTION_OFF) |
    bit_mask(POS_BUFFER_EMPTY) |
    field_mask(POS_STATE_LSB, STATE_WIDTH);

  localparam logic [31:0] COMMAND_MASK =
    bit_mask(POS_COMMAND_CHECK) |
    bit_mask(POS_ILLEGAL_COMMAND);

  // Whatever no group claims reads as zero
  localparam logic [31:0] ZERO_MASK = ~(READ_CLEAR_MASK | LEVEL_MASK | COMMAND_MASK);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  // The link copies the word in one piece, so it must fill the response field
  if (STATUS_WIDTH != $bits(STATUS_WORD_O))
  begin : gen_width_check
    $error("status width differs from the response word");
  end

  if (STATE_WIDTH != $bits(CARD_LEVELS_I.current_state))
  begin : gen_state_width_check
    $error("state field width differs from the level input");
  end

  // The handshake below is written out for exactly two stages
  if (SYNC_STAGES != 2)
  begin : gen_sync_check
    $error("synchroniser depth is fixed at two stages");
  end

  if (POS_STATE_LSB + STATE_WIDTH > STATUS_WIDTH)
  begin : gen_state_pos_check
    $error("state field lies outside the status word");
  end

  // Every event and every level must own a bit of its own
  if (count_bits(READ_CLEAR_MASK) != $bits(fault_events_s))
  begin : gen_event_count_check
    $error("event flags share a bit position");
  end

  if (count_bits(LEVEL_MASK) != $bits(card_levels_s))
  begin : gen_level_count_check
    $error("level fields share a bit position");
  end

  if ((READ_CLEAR_MASK & LEVEL_MASK) != 32'h0000_0000)
  begin : gen_level_overlap_check
    $error("level fields overlap event flags");
  end

  if (((READ_CLEAR_MASK | LEVEL_MASK) & COMMAND_MASK) != 32'h0000_0000)
  begin : gen_command_overlap_check
    $error("command flags overlap other fields");
  end

  // ------------------------------------------------------------------
  // Controller domain: read-to-clear flags
  // ------------------------------------------------------------------
  logic [31:0] sticky;
  logic [31:0] event_bits;
  logic [31:0] snap;
  logic req_sync1;
  logic req_sync2;
  logic req_seen;
  logic ack_toggle;
  logic req_toggle;
  logic read_now;

  always_comb
  begin
    event_bits = 32'h0000_0000;
    event_bits[POS_ARGUMENT_LIMIT] = FAULT_EVENTS_I.argument_limit_fault;
    event_bits[POS_ADDRESS_ALIGN] = FAULT_EVENTS_I.address_align_fault;
    event_bits[POS_BLOCK_LENGTH] = FAULT_EVENTS_I.block_length_fault;
    event_bits[POS_ERASE_ORDER] = FAULT_EVENTS_I.erase_order_fault;
    event_bits[POS_ERASE_SELECTION] = FAULT_EVENTS_I.erase_selection_fault;
    event_bits[POS_PROTECTED_WRITE] = FAULT_EVENTS_I.protected_write_attempt;
    event_bits[POS_LOCK_FAULT] = FAULT_EVENTS_I.lock_fault;
    event_bits[POS_CORRECTION_FAIL] = FAULT_EVENTS_I.correction_fail;
    event_bits[POS_CONTROLLER] = FAULT_EVENTS_I.controller_fault;
    event_bits[POS_GENERAL] = FAULT_EVENTS_I.general_fault;
    event_bits[POS_STREAM_UNDER] = FAULT_EVENTS_I.stream_read_underrun;
    event_bits[POS_STREAM_OVER] = FAULT_EVENTS_I.stream_write_overrun;
    event_bits[POS_IDENTITY_REWRITE] = FAULT_EVENTS_I.identity_register_rewrite_fault;
    event_bits[POS_ERASE_SKIP] = FAULT_EVENTS_I.erase_skip;
    event_bits[POS_ERASE_ABANDON] = FAULT_EVENTS_I.erase_abandon;
    event_bits[POS_APPLICATION_CMD] = FAULT_EVENTS_I.application_command_expected;
  end

  // ------------------------------------------------------------------
  // Request synchroniser
  // ------------------------------------------------------------------
  // Request toggle from the link; the first stage feeds only the second
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      req_sync1 <= 1'b0;
      req_sync2 <= 1'b0;
      req_seen <= 1'b0;
    end
    else
    begin
      req_sync1 <= req_toggle;
      req_sync2 <= req_sync1;
      req_seen <= req_sync2;
    end
  end

  assign read_now = req_sync2 ^ req_seen;

  // ------------------------------------------------------------------
  // Read-to-clear flags
  // ------------------------------------------------------------------
  // Read clears what was reported; an event in the same cycle still sets
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
      sticky <= STATUS_RESET;
    else if (read_now)
      sticky <= event_bits & READ_CLEAR_MASK;
    else
      sticky <= (sticky | event_bits) & READ_CLEAR_MASK;
  end

  // ------------------------------------------------------------------
  // Snapshot
  // ------------------------------------------------------------------
  // Snapshot is held stable until the next request, so the link may copy it
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      snap <= STATUS_RESET;
      ack_toggle <= 1'b0;
    end
    else if (read_now)
    begin
      snap <= sticky | event_bits;
      snap[POS_LOCK_ACTIVE] <= CARD_LEVELS_I.lock_active_flag;
      snap[POS_CORRECTION_OFF] <= CARD_LEVELS_I.correction_bypassed;
      snap[POS_STATE_LSB +: STATE_WIDTH] <= CARD_LEVELS_I.current_state;
      snap[POS_BUFFER_EMPTY] <= CARD_LEVELS_I.buffer_empty;
      ack_toggle <= ~ack_toggle;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: reset, command-cleared flags, response word
  // ------------------------------------------------------------------
  logic link_rst1;
  logic link_rst;
  logic ack_sync1;
  logic ack_sync2;
  logic ack_seen;
  logic [1:0] cmd_flags;
  logic [1:0] aged;
  logic [1:0] next_cmd_flags;
  link_state_e link_state;

  // ------------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------------
  // Reset reaches the link clock through two stages; the link clock may stop
  always_ff @(posedge CARD_CLK_I)
  begin
    link_rst1 <= RESET_I;
    link_rst <= link_rst1;
  end

  // ------------------------------------------------------------------
  // Command-cleared flags
  // ------------------------------------------------------------------
  // Bit 1 is the check failure, bit 0 the illegal command
  always_comb
  begin
    next_cmd_flags = cmd_flags;
    if (COMMAND_EVENT_I.done)
    begin
      if (COMMAND_EVENT_I.check_fail)
        next_cmd_flags = cmd_flags | 2'h2;
      else
        next_cmd_flags = (cmd_flags & ~aged) | {1'b0, COMMAND_EVENT_I.illegal};
    end
  end

  // A flag present at one valid command is dropped at the next valid one
  always_ff @(posedge CARD_CLK_I)
  begin
    if (link_rst)
    begin
      cmd_flags <= 2'h0;
      aged <= 2'h0;
    end
    else
    begin
      cmd_flags <= next_cmd_flags;
      if (COMMAND_EVENT_I.done && !COMMAND_EVENT_I.check_fail)
        aged <= next_cmd_flags;
    end
  end

  // ------------------------------------------------------------------
  // Acknowledge synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge CARD_CLK_I)
  begin
    if (link_rst)
    begin
      ack_sync1 <= 1'b0;
      ack_sync2 <= 1'b0;
      ack_seen <= 1'b0;
    end
    else
    begin
      ack_sync1 <= ack_toggle;
      ack_sync2 <= ack_sync1;
      ack_seen <= ack_sync2;
    end
  end

  // ------------------------------------------------------------------
  // Request handshake
  // ------------------------------------------------------------------
  // Load requests while a snapshot is in flight are dropped
  always_ff @(posedge CARD_CLK_I)
  begin
    if (link_rst)
    begin
      link_state <= LINK_IDLE;
      req_toggle <= 1'b0;
      SNAPSHOT_BUSY_O <= 1'b0;
    end
    else
    begin
      case (link_state)
        LINK_IDLE:
        begin
          if (RESPONSE_LOAD_I)
          begin
            req_toggle <= ~req_toggle;
            SNAPSHOT_BUSY_O <= 1'b1;
            link_state <= LINK_WAIT;
          end
        end
        LINK_WAIT:
        begin
          if (ack_sync2 ^ ack_seen)
            link_state <= LINK_TAKE;
        end
        LINK_TAKE:
        begin
          SNAPSHOT_BUSY_O <= 1'b0;
          link_state <= LINK_IDLE;
        end
        default:
          link_state <= LINK_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Response word
  // ------------------------------------------------------------------
  // Word is composed once the snapshot is stable in the controller domain
  always_ff @(posedge CARD_CLK_I)
  begin
    if (link_rst)
    begin
      STATUS_WORD_O <= STATUS_RESET;
      STATUS_VALID_O <= 1'b0;
    end
    else
    begin
      STATUS_VALID_O <= 1'b0;
      if (link_state == LINK_WAIT && (ack_sync2 ^ ack_seen))
      begin
        STATUS_WORD_O <= snap & ~ZERO_MASK;
        STATUS_WORD_O[POS_COMMAND_CHECK] <= cmd_flags[1];
        STATUS_WORD_O[POS_ILLEGAL_COMMAND] <= cmd_flags[0];
        STATUS_WORD_O[7:6] <= 2'h0;
        STATUS_WORD_O[4:0] <= 5'h00;
        STATUS_VALID_O <= 1'b1;
      end
    end
  end

endmodule

// file: testbench/card_status_register_chk.sv
// Checker: response handshake and word layout on the link side
`timescale 1ns/100ps
module card_status_register_chk
(
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CARD_CLK_I,
  input wire logic RESPONSE_LOAD_I,
  input wire logic [31:0] STATUS_WORD_O,
  input wire logic STATUS_VALID_O,
  input wire logic SNAPSHOT_BUSY_O
);
  default clocking @(posedge CARD_CLK_I);
  endclocking
  default disable iff (RESET_I);
  chk_reserved_zero: assert property (STATUS_WORD_O[7:6] == 2'h0 && STATUS_WORD_O[4:0] == 5'h00)
    else $error("reserved bits set");
  chk_valid_pulse: assert property (STATUS_VALID_O |=> !STATUS_VALID_O)
    else $error("valid longer than one cycle");
  chk_valid_busy: assert property (STATUS_VALID_O |-> SNAPSHOT_BUSY_O)
    else $error("valid without request");
  chk_load_taken: assert property (RESPONSE_LOAD_I && !SNAPSHOT_BUSY_O |=> SNAPSHOT_BUSY_O)
    else $error("load not taken");
  chk_busy_holds: assert property (SNAPSHOT_BUSY_O && !STATUS_VALID_O |=> SNAPSHOT_BUSY_O)
    else $error("busy dropped early");
  chk_busy_ends: assert property (STATUS_VALID_O ##1 1'b1 |-> !SNAPSHOT_BUSY_O)
    else $error("busy stuck after valid");
  chk_answer_bound: assert property ($rose(SNAPSHOT_BUSY_O) |-> ##[1:20] STATUS_VALID_O)
    else $error("no answer in time");
  chk_word_moves: assert property ($changed(STATUS_WORD_O) |-> STATUS_VALID_O)
    else $error("word changed without valid");
  chk_busy_cause: assert property ($rose(SNAPSHOT_BUSY_O) |-> $past(RESPONSE_LOAD_I))
    else $error("busy without load");
  cover property (STATUS_VALID_O && STATUS_WORD_O[22]);
  cover property (STATUS_VALID_O && STATUS_WORD_O[23]);
  cover property (RESPONSE_LOAD_I && SNAPSHOT_BUSY_O);
endmodule
bind card_status_register card_status_register_chk card_status_register_chk_inst
(
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .CARD_CLK_I(CARD_CLK_I), .RESPONSE_LOAD_I(RESPONSE_LOAD_I),
  .STATUS_WORD_O(STATUS_WORD_O), .STATUS_VALID_O(STATUS_VALID_O), .SNAPSHOT_BUSY_O(SNAPSHOT_BUSY_O)
);

// file: testbench/card_host_model.sv
// Host model: commands and status polls on the card clock
`timescale 1ns/100ps
module card_host_model
(
  input wire logic card_clk_i,
  input wire logic [31:0] word_i,
  input wire logic valid_i,
  input wire logic busy_i,
  output card_status_pkg::command_event_s cmd_o = '0,
  output logic load_o = 1'b0
);
  import card_status_pkg::*;
  int n_valid = 0;
  always @(posedge card_clk_i)
    if (valid_i === 1'b1)
      n_valid <= n_valid + 1;
  // Idle gap keeps commands as far apart as a real host does
  task automatic send_cmd(input logic cf, input logic il);
    @(posedge card_clk_i);
    #1 cmd_o = '{done: 1'b1, check_fail: cf, illegal: il};
    @(posedge card_clk_i);
    #1 cmd_o = '0;
    repeat (8) @(posedge card_clk_i);
  endtask
  // Execution flags are only seen by polling; twice repeats the load while busy
  task automatic read_status(input logic twice, output logic [31:0] w, output logic ok);
    ok = 1'b0;
    w = '0;
    @(posedge card_clk_i);
    #1 load_o = 1'b1;
    @(posedge card_clk_i);
    #1 load_o = twice;
    @(posedge card_clk_i);
    #1 load_o = 1'b0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge card_clk_i);
      #1 ok = (valid_i === 1'b1);
      w = word_i;
    end
    for (int i = 0; i < 4 && busy_i !== 1'b0; i++)
      @(posedge card_clk_i);
  endtask
endmodule

// file: testbench/card_status_register_tb_top.sv
// Testbench: random faults, levels and commands against polled status words
`timescale 1ns/100ps
module card_status_register_tb_top;
  import card_status_pkg::*;
  logic MCLK_I = 1'b0;
  logic CARD_CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  fault_events_s fev = '0;
  card_levels_s lev = '0;
  command_event_s cmd;
  logic load;
  logic [31:0] word;
  logic valid;
  logic busy;
  logic [31:0] seed = 32'h24d7_954f;
  logic [15:0] acc = '0;
  logic b23 = 1'b0, b22 = 1'b0, p23 = 1'b0, p22 = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;
  initial
    forever #50 MCLK_I = ~MCLK_I;
  initial
  begin
    #17;
    forever #24 CARD_CLK_I = ~CARD_CLK_I;
  end
  card_status_register card_status_register_inst
  (
    .MCLK_I(MCLK_I), .RESET_I(RESET_I), .FAULT_EVENTS_I(fev), .CARD_LEVELS_I(lev),
    .CARD_CLK_I(CARD_CLK_I), .COMMAND_EVENT_I(cmd), .RESPONSE_LOAD_I(load),
    .STATUS_WORD_O(word), .STATUS_VALID_O(valid), .SNAPSHOT_BUSY_O(busy)
  );
  card_host_model card_host_model_inst
  (
    .card_clk_i(CARD_CLK_I), .word_i(word), .valid_i(valid), .busy_i(busy),
    .cmd_o(cmd), .load_o(load)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] exp_word(input logic [15:0] f, input logic [6:0] v);
    return {f[15:10], v[6], f[9], b23, b22, f[8:2], v[5], f[1], v[3:0], v[4], 2'h0, f[0],
      5'h00};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    num_checks++;
    if ((got & m) !== (exp & m))
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask
  // Check failure survives one valid command, illegal clears at the next one
  task automatic command(input logic cf, input logic il);
    card_host_model_inst.send_cmd(cf, il);
    if (cf)
      b23 = 1'b1;
    else
    begin
      b23 = b23 & ~p23;
      b22 = (b22 & ~p22) | il;
      p23 = b23;
      p22 = b22;
    end
  endtask
  task automatic step(input int k, input logic twice, input logic [6:0] v);
    logic [31:0] w;
    logic [31:0] e;
    logic ok;
    int nv;
    seed = lfsr(seed);
    @(posedge MCLK_I);
    #1 fev = seed[15:0];
    lev = v;
    @(posedge MCLK_I);
    #1 fev = '0;
    acc = acc | seed[15:0];
    if (seed[16] && k >= 20)
      command(seed[17] & seed[18], seed[19]);
    nv = card_host_model_inst.n_valid;
    card_host_model_inst.read_status(twice, w, ok);
    e = exp_word(acc, v);
    acc = '0;
    repeat (12) @(posedge CARD_CLK_I);
    cmp({31'h0, ok}, 32'h1, 32'h1);
    cmp(32'(card_host_model_inst.n_valid - nv), 32'h1, 32'hffff_ffff);
    cmp({31'h0, busy}, 32'h0, 32'h1);
    cmp(w, e, 32'hff00_0000);
    cmp(w, e, 32'h00c0_0000);
    cmp(w, e, 32'h003f_e000);
    cmp(w, e, 32'h0000_1f00);
    cmp(w, e, 32'h0000_00ff);
    $display("test %0d done", k);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge MCLK_I);
    #1 RESET_I = 1'b0;
    repeat (4) @(posedge CARD_CLK_I);
    for (int i = 0; i < 4; i++)
    begin
      command(i == 0, i == 1);
      step(i, 1'b0, 7'h00);
    end
    for (int s = 0; s < 16; s++)
    begin
      seed = lfsr(seed);
      step(s + 4, s[0], {seed[2:0], 4'(s)});
    end
    for (int k = 20; k < 60; k++)
    begin
      seed = lfsr(seed);
      step(k, seed[5], seed[28:22]);
    end
    summarize();
  end
endmodule
